/* hjps_device.sv */
`timescale 1ns/1ps
module hjps_device #(
	parameter int NREG = hjps_pkg::NREG_DEF,
	parameter int VID_HALF = hjps_pkg::VID_HALF_DEF,
	parameter logic [hjps_pkg::DR_W-1:0] IDCODE = hjps_pkg::IDCODE_DEF
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	hjps_link_if.dev link,
	output logic [hjps_pkg::REG_W-1:0] ctrl_out,
	output logic [hjps_pkg::IR_W-1:0] ir_out,
	output logic tap_reset_out
);
	import hjps_pkg::*;

	localparam int AW = $clog2(NREG);
	localparam int VC_W = 16;

	typedef struct packed {
		logic sclk_q;
		logic [BCNT_W-1:0] bitcnt;
		logic [REG_W-1:0] in_sh;
		logic [REG_W-1:0] cmd;
		logic [REG_W-1:0] out_sh;
		logic [NREG-1:0][REG_W-1:0] regs;
		logic [REG_W-1:0] frames;
		logic sout;
		logic sout_oe_n;
		hjps_tap_e tap;
		logic [IR_W-1:0] ir;
		logic [IR_W-1:0] ir_sh;
		logic [DR_W-1:0] dr_sh;
		logic [VC_W-1:0] vid_cnt;
		logic vid_a;
		logic vid_b;
	} hjps_dev_s;

	hjps_dev_s st;
	hjps_dev_s next_st;
	logic [SYNC_W-1:0] sy;

	// ==========================================
	// Helpers

	// Default contents, shared by the core reset and the reset pin
	function automatic hjps_dev_s dev_reset();
		dev_reset = '0;
		dev_reset.tap = TAP_RESET;
		dev_reset.ir = IR_IDCODE;
		dev_reset.sout_oe_n = 1'b1;
		dev_reset.regs[0] = REG0_RESET;
	endfunction

	// Readback: status word at a fixed address, unmapped reads give zero
	function automatic logic [REG_W-1:0] reg_read(input logic [ADDR_W-1:0] a,
			input hjps_dev_s s);
		reg_read = '0;
		if (a == STATUS_ADDR) begin
			reg_read = s.frames;
		end else if (int'(a) < NREG) begin
			reg_read = s.regs[a[AW-1:0]];
		end
	endfunction

	// Scan controller transition on one rising test clock edge
	function automatic hjps_tap_e tap_next(input hjps_tap_e s, input logic tms);
		case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	// ==========================================
	// Pin synchronisers
	hjps_sync #(
		.W(SYNC_W)
	) u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.d_in({link.reset_n_pin, link.function_select_pin, link.shared_select_pin,
			link.shared_serial_input_pin, link.shared_serial_clock_pin}),
		.q_out(sy)
	);

	// ==========================================
	// Next-state logic
	logic rise;
	logic fall;
	logic jtag_mode;
	logic cs_act;
	logic sin;
	logic [REG_W-1:0] cmd_word;

	// Edges of the shared clock as seen in the core domain
	assign rise = sy[SY_SCLK] & ~st.sclk_q;
	assign fall = ~sy[SY_SCLK] & st.sclk_q;
	assign jtag_mode = sy[SY_MODE];
	assign cs_act = ~jtag_mode & ~sy[SY_SEL];
	assign sin = sy[SY_SIN];
	assign cmd_word = {st.in_sh[REG_W-2:0], sin};

	always_comb begin
		next_st = st;
		next_st.sclk_q = sy[SY_SCLK];

		// Host register port, active only with the select pin low
		if (!jtag_mode) begin
			next_st.tap = TAP_RESET;
			if (!cs_act) begin
				next_st.bitcnt = '0;
				next_st.sout_oe_n = 1'b1;
			end else if (rise && st.bitcnt < BCNT_W'(FRAME_BITS)) begin
				next_st.in_sh = cmd_word;
				next_st.bitcnt = st.bitcnt + BCNT_W'(1);
				if (st.bitcnt == BCNT_W'(CMD_BITS - 1)) begin
					next_st.cmd = cmd_word;
					next_st.out_sh = reg_read(cmd_word[ADDR_W-1:0], st);
				end
				if (st.bitcnt == BCNT_W'(FRAME_BITS - 1)) begin
					next_st.frames = st.frames + REG_W'(1);
					// Writes land only once the whole data byte is in
					if (!st.cmd[READ_BIT] && int'(st.cmd[ADDR_W-1:0]) < NREG) begin
						next_st.regs[st.cmd[AW-1:0]] = cmd_word;
					end
				end
			end else if (fall && st.cmd[READ_BIT] && st.bitcnt >= BCNT_W'(CMD_BITS)
					&& st.bitcnt < BCNT_W'(FRAME_BITS)) begin
				next_st.sout = st.out_sh[REG_W-1];
				next_st.out_sh = {st.out_sh[REG_W-2:0], 1'b0};
				next_st.sout_oe_n = 1'b0;
			end
		end else begin
			// Test port: sample on rising, drive on falling test clock
			next_st.bitcnt = '0;
			if (rise) begin
				case (st.tap)
					TAP_CAP_DR: begin
						next_st.dr_sh = (st.ir == IR_IDCODE) ? IDCODE : '0;
					end
					TAP_SHIFT_DR: begin
						if (st.ir == IR_IDCODE) begin
							next_st.dr_sh = {sin, st.dr_sh[DR_W-1:1]};
						end else begin
							next_st.dr_sh = {{(DR_W-1){1'b0}}, sin};
						end
					end
					TAP_CAP_IR: begin
						next_st.ir_sh = IR_CAPTURE;
					end
					TAP_SHIFT_IR: begin
						next_st.ir_sh = {sin, st.ir_sh[IR_W-1:1]};
					end
					TAP_UPD_IR: begin
						next_st.ir = st.ir_sh;
					end
					default: begin
					end
				endcase
				next_st.tap = tap_next(st.tap, sy[SY_SEL]);
			end
			if (fall) begin
				next_st.sout = (st.tap == TAP_SHIFT_DR) ? st.dr_sh[0] : st.ir_sh[0];
				next_st.sout_oe_n = ~(st.tap == TAP_SHIFT_DR || st.tap == TAP_SHIFT_IR);
			end
			if (st.tap == TAP_RESET) begin
				next_st.ir = IR_IDCODE;
			end
		end

		// Video clocks from the core clock, each gated by its enable bit
		if (st.vid_cnt == VC_W'(VID_HALF - 1)) begin
			next_st.vid_cnt = '0;
			next_st.vid_a = st.regs[0][VA_EN_BIT] & ~st.vid_a;
			next_st.vid_b = st.regs[0][VB_EN_BIT] & ~st.vid_b;
		end else begin
			next_st.vid_cnt = st.vid_cnt + VC_W'(1);
		end

		// Reset pin low: defaults, output floats, test sequencer held
		if (!sy[SY_RSTN]) begin
			next_st = dev_reset();
			next_st.sclk_q = sy[SY_SCLK];
		end
		// Release needs no extra step: logic simply runs from defaults
	end

	// ==========================================
	// State register
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st <= dev_reset();
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs, all from flip-flops except tap_reset_out, decoded from st.tap
	assign link.shared_serial_output_pin = st.sout;
	assign link.shared_serial_output_oe_n = st.sout_oe_n;
	assign link.video_clock_out_a = st.vid_a;
	assign link.video_clock_out_b = st.vid_b;
	assign ctrl_out = st.regs[0];
	assign ir_out = st.ir;
	assign tap_reset_out = (st.tap == TAP_RESET);
endmodule

/* hjps_host.sv */
`timescale 1ns/1ps
module hjps_host #(
	parameter int HALF_DIV = hjps_pkg::LINK_HALF_CYC,
	parameter int RST_CYC = hjps_pkg::RESET_HOLD_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	hjps_link_if.host link,
	input wire logic mode_in,
	input wire logic start_in,
	input wire logic [hjps_pkg::FRAME_BITS-1:0] sel_vec_in,
	input wire logic [hjps_pkg::FRAME_BITS-1:0] data_vec_in,
	input wire logic reset_req_in,
	output logic busy_out,
	output logic done_out,
	output logic [hjps_pkg::FRAME_BITS-1:0] rdata_out
);
	import hjps_pkg::*;

	typedef struct packed {
		hjps_hst_e state;
		logic [31:0] cnt;
		logic [BCNT_W-1:0] bitn;
		logic mode;
		logic sclk;
		logic sin;
		logic sel;
		logic rstn;
		logic [FRAME_BITS-1:0] tx_sel;
		logic [FRAME_BITS-1:0] tx_dat;
		logic [FRAME_BITS-1:0] rx;
		logic [FRAME_BITS-1:0] rdata;
		logic done;
	} hjps_host_s;

	hjps_host_s st;
	hjps_host_s next_st;
	logic sout_sy;

	// ==========================================
	// Returned data is a pin from the far end
	hjps_sync #(
		.W(1)
	) u_sync (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.d_in(link.shared_serial_output_level),
		.q_out(sout_sy)
	);

	// ==========================================
	// Sequencer: reset hold, then 16-bit frames on a divided clock
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.cnt = st.cnt + 32'd1;
		case (st.state)
			HST_RESET: begin
				next_st.rstn = 1'b0;
				if (st.cnt >= 32'(RST_CYC - 1)) begin
					next_st.state = HST_IDLE;
					next_st.rstn = 1'b1;
				end
			end
			HST_IDLE: begin
				next_st.cnt = '0;
				// Idle select: chip select high in host mode, TMS low in test mode
				next_st.sel = ~st.mode;
				if (reset_req_in) begin
					next_st.state = HST_RESET;
					next_st.rstn = 1'b0;
				end else if (start_in) begin
					next_st.state = HST_LOW;
					next_st.mode = mode_in;
					next_st.bitn = '0;
					next_st.tx_sel = sel_vec_in;
					next_st.tx_dat = data_vec_in;
					next_st.sin = data_vec_in[FRAME_BITS-1];
					next_st.sel = mode_in & sel_vec_in[FRAME_BITS-1];
				end
			end
			HST_LOW: begin
				if (st.cnt == 32'(HALF_DIV - 1)) begin
					next_st.cnt = '0;
					next_st.sclk = 1'b1;
					next_st.rx = {st.rx[FRAME_BITS-2:0], sout_sy};
					next_st.state = HST_HIGH;
				end
			end
			HST_HIGH: begin
				if (st.cnt == 32'(HALF_DIV - 1)) begin
					next_st.cnt = '0;
					next_st.sclk = 1'b0;
					if (st.bitn == BCNT_W'(FRAME_BITS - 1)) begin
						next_st.state = HST_IDLE;
						next_st.done = 1'b1;
						next_st.rdata = st.rx;
					end else begin
						next_st.state = HST_LOW;
						next_st.bitn = st.bitn + BCNT_W'(1);
						next_st.tx_sel = {st.tx_sel[FRAME_BITS-2:0], 1'b0};
						next_st.tx_dat = {st.tx_dat[FRAME_BITS-2:0], 1'b0};
						next_st.sin = st.tx_dat[FRAME_BITS-2];
						next_st.sel = st.mode & st.tx_sel[FRAME_BITS-2];
					end
				end
			end
			default: begin
				next_st.state = HST_RESET;
			end
		endcase
	end

	// Core reset starts the device reset hold at once
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st <= '0;
			st.state <= HST_RESET;
			st.sel <= 1'b1;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	assign link.shared_serial_clock_pin = st.sclk;
	assign link.shared_serial_input_pin = st.sin;
	assign link.shared_select_pin = st.sel;
	assign link.function_select_pin = st.mode;
	assign link.reset_n_pin = st.rstn;
	assign busy_out = (st.state != HST_IDLE);
	assign done_out = st.done;
	assign rdata_out = st.rdata;
endmodule

/* hjps_link_if.sv */
`timescale 1ns/1ps
interface hjps_link_if;
	// ==========================================
	// Pins from the host side
	logic shared_serial_clock_pin;
	logic shared_serial_input_pin;
	logic shared_select_pin;
	logic function_select_pin;
	logic reset_n_pin;
	// ==========================================
	// Pins from the device side
	logic shared_serial_output_pin;
	logic shared_serial_output_oe_n;
	logic video_clock_out_a;
	logic video_clock_out_b;
	// Board pull-up: an undriven output line reads high
	logic shared_serial_output_level;
	assign shared_serial_output_level = shared_serial_output_oe_n ? 1'b1 : shared_serial_output_pin;

	modport dev (
		input shared_serial_clock_pin,
		input shared_serial_input_pin,
		input shared_select_pin,
		input function_select_pin,
		input reset_n_pin,
		output shared_serial_output_pin,
		output shared_serial_output_oe_n,
		output video_clock_out_a,
		output video_clock_out_b
	);

	modport host (
		output shared_serial_clock_pin,
		output shared_serial_input_pin,
		output shared_select_pin,
		output function_select_pin,
		output reset_n_pin,
		input shared_serial_output_level,
		input video_clock_out_a,
		input video_clock_out_b
	);
endinterface

/* hjps_link_sva.sv */
`timescale 1ns/1ps
// ==========================================
// Link checker: watches the shared pins between host and device
module hjps_link_sva (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic shared_serial_clock_pin,
	input wire logic shared_serial_input_pin,
	input wire logic shared_select_pin,
	input wire logic function_select_pin,
	input wire logic reset_n_pin,
	input wire logic shared_serial_output_oe_n,
	input wire logic video_clock_out_a,
	input wire logic video_clock_out_b
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	// Four low samples so the pin has passed the device synchroniser
	sequence s_reset_held;
		(!reset_n_pin) [*4];
	endsequence

	// Host port parked between frames, long enough for the output to let go
	sequence s_host_quiet;
		(!function_select_pin && shared_select_pin) [*6];
	endsequence

	a_reset_vid_low: assert property (
		s_reset_held |-> !video_clock_out_a && !video_clock_out_b && shared_serial_output_oe_n)
		else $error("device pins active while reset pin is low");
	a_host_out_float: assert property (
		s_host_quiet |-> shared_serial_output_oe_n)
		else $error("output driven while chip select is high");
	a_idle_clock_low: assert property (
		!function_select_pin && shared_select_pin |-> !shared_serial_clock_pin)
		else $error("serial clock high outside a host frame");
	a_sin_steady: assert property (
		shared_serial_clock_pin |-> $stable(shared_serial_input_pin))
		else $error("serial input moved while clock high");
	a_sel_steady: assert property (
		shared_serial_clock_pin |-> $stable(shared_select_pin) && $stable(function_select_pin))
		else $error("select or function pin moved while clock high");
	a_test_out_fall: assert property (
		function_select_pin && $changed(shared_serial_output_oe_n) |-> !shared_serial_clock_pin)
		else $error("test output enable moved while clock high");
	a_host_out_fall: assert property (
		!function_select_pin && $fell(shared_serial_output_oe_n)
		|-> !shared_serial_clock_pin && !shared_select_pin)
		else $error("host output turned on outside a selected low clock phase");
	// Register 0 defaults enable clock a, so it must start soon after release
	a_release_resume: assert property (
		$rose(reset_n_pin) |-> ##[1:16] video_clock_out_a)
		else $error("video clock a not running after reset release");
endmodule

/* hjps_pkg.sv */
package hjps_pkg;
	// ==========================================
	// Synchroniser lanes on the device side
	localparam int SYNC_W = 5;
	localparam int SY_SCLK = 0;
	localparam int SY_SIN = 1;
	localparam int SY_SEL = 2;
	localparam int SY_MODE = 3;
	localparam int SY_RSTN = 4;

	// ==========================================
	// Host serial framing: command byte then data byte, MSB first
	localparam int BCNT_W = 5;
	localparam int CMD_BITS = 8;
	localparam int FRAME_BITS = 16;
	localparam int READ_BIT = 7;
	localparam int REG_W = 8;
	localparam int ADDR_W = 7;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 7'h7f;
	localparam int NREG_DEF = 4;
	localparam int VA_EN_BIT = 0;
	localparam int VB_EN_BIT = 1;
	localparam logic [REG_W-1:0] REG0_RESET = 8'h03;
	localparam int VID_HALF_DEF = 4;

	// ==========================================
	// Test port instruction register
	localparam int IR_W = 4;
	localparam int DR_W = 32;
	localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	// Arbitrary value, bit 0 set as the scan standard expects
	localparam logic [DR_W-1:0] IDCODE_DEF = 32'h0a5c_3e01;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_HOLD_US = 500;
	localparam int RESET_HOLD_CYC = (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// ==========================================
	// State types
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} hjps_tap_e;

	typedef enum logic [1:0] {
		HST_RESET, HST_IDLE, HST_LOW, HST_HIGH
	} hjps_hst_e;
endpackage

/* hjps_sync.sv */
`timescale 1ns/1ps
module hjps_sync #(
	parameter int W = 1
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	import hjps_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hjps_sync_s;

	hjps_sync_s st;
	hjps_sync_s next_st;

	// First stage feeds only the second stage
	always_comb begin
		next_st = st;
		next_st.s1 = d_in;
		next_st.s2 = st.s1;
	end

	// Clears to zero, so an active-low lane reads asserted until sampled
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	assign q_out = st.s2;
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import hjps_pkg::*;
	localparam int HALF = 8;
	localparam int NREG = NREG_DEF;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic start = 1'b0;
	logic mode = 1'b0;
	logic reset_req = 1'b0;
	logic [FRAME_BITS-1:0] sel_vec = '0;
	logic [FRAME_BITS-1:0] data_vec = '0;
	logic busy;
	logic done;
	logic [FRAME_BITS-1:0] rdata;
	logic [REG_W-1:0] ctrl;
	logic [IR_W-1:0] ir;
	logic tap_rst;
	logic [FRAME_BITS-1:0] exp_q[$];
	int fails = 0;
	int checked = 0;

	// ==========================================
	// Both ends joined over the link
	hjps_link_if link();
	hjps_host #(.HALF_DIV(HALF), .RST_CYC(20)) i_hjps_host (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1), .link(link),
		.mode_in(mode), .start_in(start), .sel_vec_in(sel_vec), .data_vec_in(data_vec),
		.reset_req_in(reset_req), .busy_out(busy), .done_out(done), .rdata_out(rdata));
	hjps_device #(.NREG(NREG)) i_hjps_device (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1), .link(link),
		.ctrl_out(ctrl), .ir_out(ir), .tap_reset_out(tap_rst));
	hjps_link_sva i_hjps_link_sva (
		.core_clk_in(core_clk_in), .rst_in(rst_in),
		.shared_serial_clock_pin(link.shared_serial_clock_pin),
		.shared_serial_input_pin(link.shared_serial_input_pin),
		.shared_select_pin(link.shared_select_pin),
		.function_select_pin(link.function_select_pin),
		.reset_n_pin(link.reset_n_pin),
		.shared_serial_output_oe_n(link.shared_serial_output_oe_n),
		.video_clock_out_a(link.video_clock_out_a),
		.video_clock_out_b(link.video_clock_out_b));

	// ==========================================
	// Clock, checks and closing
	initial begin
		forever #5 core_clk_in = ~core_clk_in;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Bounded so a stuck host shows as a failure, not a hang
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge core_clk_in);
			n++;
		end
		if (n >= 3000) begin
			fails++;
			$display("CHECK FAILED at %0t: host never went idle", $time);
		end
	endtask

	// One 16-bit frame; the expected read-back goes to the queue
	task automatic frame(input logic m, input logic [15:0] s, input logic [15:0] d,
			input logic [15:0] e);
		wait_idle();
		@(posedge core_clk_in);
		#1;
		mode = m;
		sel_vec = s;
		data_vec = d;
		start = 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk_in);
		#1;
		start = 1'b0;
		repeat (2) @(posedge core_clk_in);
		wait_idle();
		repeat (6) @(posedge core_clk_in);
	endtask

	task automatic pin_reset();
		wait_idle();
		@(posedge core_clk_in);
		#1;
		reset_req = 1'b1;
		@(posedge core_clk_in);
		#1;
		reset_req = 1'b0;
		repeat (5) @(posedge core_clk_in);
		check(16'(tap_rst), 16'h0001, "scan held in reset");
		check(16'(ctrl), 16'(REG0_RESET), "register 0 default in reset");
		wait_idle();
		repeat (6) @(posedge core_clk_in);
	endtask

	// Result watcher: done stands one cycle, taken mid-cycle to stay clear of its launch edge
	always @(negedge core_clk_in) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("CHECK FAILED at %0t: result with nothing expected", $time);
			end else begin
				check(rdata, exp_q.pop_front(), "frame read-back");
			end
		end
	end

	initial begin
		repeat (60000) @(posedge core_clk_in);
		fails++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [15:0] d;
		logic [7:0] b;
		logic [11:0] rev;
		d = 16'($urandom(32'h18242a8d));
		for (int i = 0; i < 12; i++) begin
			rev[11 - i] = IDCODE_DEF[i];
		end
		repeat (8) @(posedge core_clk_in);
		#1;
		rst_in = 1'b0;
		wait_idle();
		check(16'(ctrl), 16'(REG0_RESET), "register 0 default");
		check(16'(ir), 16'(IR_IDCODE), "instruction default");
		// Host mode: writes float the output, reads return the byte
		for (int a = 1; a < NREG; a++) begin
			b = 8'($urandom());
			frame(1'b0, 16'h0, {1'b0, 7'(a), b}, 16'hffff);
			frame(1'b0, 16'h0, {1'b1, 7'(a), 8'h00}, {8'hff, b});
		end
		frame(1'b0, 16'h0, {1'b1, 7'h00, 8'h00}, {8'hff, REG0_RESET});
		frame(1'b0, 16'h0, {1'b1, 7'h10, 8'h00}, 16'hff00);
		frame(1'b0, 16'h0, {1'b1, STATUS_ADDR, 8'h00}, {8'hff, 8'(2 * NREG)});
		frame(1'b0, 16'h0, {1'b0, 7'h00, 8'h01}, 16'hffff);
		check(16'(ctrl), 16'h0001, "register 0 write");
		pin_reset();
		check(16'(ctrl), 16'(REG0_RESET), "register 0 after release");
		// Test mode: reset walk, identity scan, instruction load, bypass
		frame(1'b1, 16'hffff, d, 16'hffff);
		check(16'(tap_rst), 16'h0001, "scan reset by mode select");
		frame(1'b1, 16'h4000, d, {4'hf, rev});
		frame(1'b1, 16'hffff, d, 16'hffff);
		check(16'(tap_rst), 16'h0001, "scan reset from shift state");
		// Four shifts in the instruction path: capture, shift, exit on the fourth bit
		frame(1'b1, 16'h60c0, 16'hffff, 16'hfc7f);
		check(16'(ir), 16'(IR_BYPASS), "instruction loaded");
		d = 16'($urandom());
		frame(1'b1, 16'h8000, d, {4'he, d[12:1]});
		pin_reset();
		check(16'(ir), 16'(IR_IDCODE), "instruction after reset");
		frame(1'b1, 16'h4000, d, {4'hf, rev});
		check(16'(exp_q.size()), 16'h0000, "pending results");
		give_verdict();
	end
endmodule
